// [common/ipauth_regs.vh]
// Purpose: constants of the IP authentication command engine
// Assumes: bytes of one command may arrive before its header is taken, up to the FIFO depth
// Notes: status words and secret kind codes are local encodings
// Function
// [R1] Command recognised by class 80 and instruction 80 only.
// [R2] First parameter byte 00..04 selects CHAP, HA, RRQ hash, AAA, packet-access.
// [R3] Terminal issues HA, then RRQ hash, then AAA for Mobile IP.
// [R4] RRQ hash or AAA out of order answers status 98 34.
// [R5] Repeated HA operations before RRQ hash and AAA are accepted.
// [R6] CHAP: parameters 00 00, data is identifier, slot index, challenge.
// [R7] CHAP returns 16-byte hash of identifier, simple IP secret, challenge.
// [R8] CHAP slot index selects which simple IP secret is hashed.
// [R9] Hash engine sits outside behind a byte port, replaceable.
// [R10] Terminal splits registration data above 254 bytes into chained blocks.
// [R11] Chained HA blocks out of order answer status 98 34.
// [R12] Second parameter byte: 00 first, 01 next, 02 single, 03 last.
// [R13] HA returns nothing for first/next, 16 bytes after single/last.
// [R14] HA first/single data starts with slot index, then registration data.
// [R15] HA hashes the slot-selected home agent secret with protected fields.
// [R16] RRQ hash is computed and kept internally, never returned.
// [R17] AAA combines kept RRQ hash, challenge and slot-selected AAA secret.
// [R18] Packet-access operation returns CHAP response for the forwarded challenge.
// [R19] HA authenticator hashes secret, whole registration message, secret again.
// [R20] RRQ single/last data ends with 8-byte AAA extension header, hashed too.
// [R21] AAA hashes high challenge byte, AAA secret, RRQ hash, low challenge bytes.
// [R22] Packet-access hashes identifier, packet-access secret, challenge.
// [R23] Bad operation or chaining value gives error status, no computation.
// [R24] Tracker returns idle after completed AAA or any ordering error.
`ifndef IPAUTH_REGS_VH
`define IPAUTH_REGS_VH

`define IPA_CLA           8'h80
`define IPA_INS           8'h80

`define IPA_OP_CHAP       3'h0
`define IPA_OP_HA         3'h1
`define IPA_OP_RRQ        3'h2
`define IPA_OP_AAA        3'h3
`define IPA_OP_PKT        3'h4

`define IPA_P2_FIRST      2'h0
`define IPA_P2_NEXT       2'h1
`define IPA_P2_SINGLE     2'h2
`define IPA_P2_LAST       2'h3

`define IPA_SW_OK         16'h9000
`define IPA_SW_SEQ        16'h9834
`define IPA_SW_PARAM      16'h6B00
`define IPA_SW_LEN        16'h6700
`define IPA_SW_CLA        16'h6E00
`define IPA_SW_INS        16'h6D00

`define IPA_DIGEST_BYTES  5'h10
`define IPA_EXT_HDR_BYTES 8'h08
`define IPA_AAA_LOW_MAX   8'hED

`define IPA_KIND_SIMPLE   2'h0
`define IPA_KIND_HA       2'h1
`define IPA_KIND_AAA      2'h2
`define IPA_KIND_PKT      2'h3

`endif

// [verilog/ipauth_fifo.v]
// Purpose: byte FIFO between command data input and engine
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; storage is flip-flops
`timescale 1ns/1ps
`default_nettype none

module ipauth_fifo #(
	parameter WIDTH  = 8,
	parameter DEPTH  = 8,
	parameter ADDR_W = 3
) (
	input  wire             clk_sys,
	input  wire             resetn,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);

	reg [WIDTH-1:0]  mem [0:DEPTH-1];
	reg [ADDR_W-1:0] wrPtr;
	reg [ADDR_W-1:0] rdPtr;
	reg [ADDR_W:0]   count;

	wire push = inValid & inReady;
	wire pop  = outValid & outReady;

	assign inReady  = (count != DEPTH[ADDR_W:0]);
	assign outValid = (count != {(ADDR_W+1){1'b0}});
	assign outData  = mem[rdPtr];

	always @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			wrPtr <= {ADDR_W{1'b0}};
			rdPtr <= {ADDR_W{1'b0}};
			count <= {(ADDR_W+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rdPtr + 1'b1;
			end
			if (push & !pop) begin
				count <= count + 1'b1;
			end else if (pop & !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule // ipauth_fifo

`default_nettype wire

// [verilog/ipauth_command_engine.v]
// Purpose: card-side engine for the compute IP authentication command
// Assumes: up to FIFO_DEPTH data bytes may arrive before their header is taken; secret store answers in the same cycle
// Notes: hash engine is external, fed one byte at a time, restarted by hashStart
`include "ipauth_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module ipauth_command_engine #(
	parameter FIFO_DEPTH  = 8,
	parameter FIFO_ADDR_W = 3
) (
	input  wire         clk_sys,
	input  wire         resetn,
	// Command header
	input  wire         cmdValid,
	output wire         cmdReady,
	input  wire [7:0]   cmdClass,
	input  wire [7:0]   cmdIns,
	input  wire [7:0]   cmdP1,
	input  wire [7:0]   cmdP2,
	input  wire [7:0]   cmdLc,
	// Command data bytes
	input  wire         dataValid,
	output wire         dataReady,
	input  wire [7:0]   dataByte,
	// Response
	output wire         respValid,
	output reg  [7:0]   respSw1,
	output reg  [7:0]   respSw2,
	output reg  [4:0]   respLen,
	output reg  [127:0] respDigest,
	// Secret store
	output reg  [1:0]   secretKind,
	output reg  [7:0]   secretSlot,
	output reg  [5:0]   secretIdx,
	input  wire [7:0]   secretByte,
	input  wire [5:0]   secretLen,
	// Hash engine
	output reg          hashStart,
	output reg          hashValid,
	input  wire         hashReady,
	output reg  [7:0]   hashByte,
	output reg          hashFinish,
	input  wire         hashDone,
	input  wire [127:0] hashDigest
);

	localparam S_IDLE   = 8'h01;
	localparam S_DATA   = 8'h02;
	localparam S_SECRET = 8'h04;
	localparam S_TAIL   = 8'h08;
	localparam S_FINISH = 8'h10;
	localparam S_WAIT   = 8'h20;
	localparam S_DRAIN  = 8'h40;
	localparam S_RESP   = 8'h80;

	localparam M_IDLE = 3'h1;
	localparam M_HA   = 3'h2;
	localparam M_RRQ  = 3'h4;

	reg [7:0]   state;
	reg [2:0]   mipState;
	reg         haChain;
	reg         rrqChain;
	reg [2:0]   op;
	reg [1:0]   chain;
	reg [7:0]   lc;
	reg [7:0]   cnt;
	reg [7:0]   slot;
	reg [7:0]   highByte;
	reg [4:0]   tailIdx;
	reg         secretEnd;
	reg [127:0] rrqHash;

	wire       fifoValid;
	wire       fifoReady;
	wire [7:0] fifoByte;

	ipauth_fifo #(
		.WIDTH  (8),
		.DEPTH  (FIFO_DEPTH),
		.ADDR_W (FIFO_ADDR_W)
	) u_fifo (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.inValid  (dataValid),
		.inReady  (dataReady),
		.inData   (dataByte),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoByte)
	);

	wire canEmit   = !hashValid | hashReady;
	wire bytesLeft = (cnt != lc);
	wire isFs      = (chain == `IPA_P2_FIRST) | (chain == `IPA_P2_SINGLE);
	wire isEnd     = (chain == `IPA_P2_SINGLE) | (chain == `IPA_P2_LAST);
	wire pop       = fifoValid & fifoReady;

	assign fifoReady = (state == S_DATA) ? (bytesLeft & canEmit) :
	                   (state == S_DRAIN) ? bytesLeft : 1'b0;
	assign cmdReady  = (state == S_IDLE);
	assign respValid = (state == S_RESP);

	// Slot index bytes never enter the hash
	wire slotPos = ((op == `IPA_OP_CHAP) & (cnt == 8'h01)) | // R8
	               ((op == `IPA_OP_HA) & isFs & (cnt == 8'h00)) | // R14
	               ((op == `IPA_OP_AAA) & (cnt == 8'h00)); // R17
	// Byte after which the secret is inserted
	wire secretAfter = ((op == `IPA_OP_CHAP) & (cnt == 8'h01)) | // R7
	                   ((op == `IPA_OP_HA) & isFs & (cnt == 8'h00)) | // R19
	                   ((op == `IPA_OP_AAA) & (cnt == 8'h01)) | // R21
	                   ((op == `IPA_OP_PKT) & (cnt == 8'h00)); // R22

	// Short challenge: high byte goes in a second time with the low part
	wire replay = (lc <= `IPA_AAA_LOW_MAX + 8'h01); // R21

	wire [127:0] tailWord = rrqHash << {tailIdx[3:0], 3'b000};
	wire [15:0]  swOk     = `IPA_SW_OK;

	// Header check
	reg [15:0] hdrSw;
	reg        hdrSeqErr;
	reg        hdrOk;
	reg        hdrStart;
	reg [1:0]  hdrKind;

	always @* begin
		hdrSw     = `IPA_SW_OK;
		hdrSeqErr = 1'b0;
		hdrStart  = 1'b1;
		hdrKind   = `IPA_KIND_SIMPLE;
		if (cmdClass != `IPA_CLA) begin
			hdrSw = `IPA_SW_CLA; // R1
		end else if (cmdIns != `IPA_INS) begin
			hdrSw = `IPA_SW_INS; // R1
		end else begin
			case (cmdP1)
				8'h00: begin
					hdrKind = `IPA_KIND_SIMPLE;
					if (cmdP2 != 8'h00) begin
						hdrSw = `IPA_SW_PARAM; // R23
					end else if (cmdLc < 8'h02) begin
						hdrSw = `IPA_SW_LEN; // R6
					end
				end
				8'h01: begin
					hdrKind  = `IPA_KIND_HA;
					hdrStart = (cmdP2[1:0] == `IPA_P2_FIRST) | (cmdP2[1:0] == `IPA_P2_SINGLE);
					if (cmdP2 > 8'h03) begin
						hdrSw = `IPA_SW_PARAM; // R23
					end else if (hdrStart ? (haChain | rrqChain) : !haChain) begin
						hdrSw     = `IPA_SW_SEQ; // R11
						hdrSeqErr = 1'b1;
					end else if (hdrStart & (cmdLc == 8'h00)) begin
						hdrSw = `IPA_SW_LEN; // R14
					end
				end
				8'h02: begin
					hdrStart = (cmdP2[1:0] == `IPA_P2_FIRST) | (cmdP2[1:0] == `IPA_P2_SINGLE);
					if (cmdP2 > 8'h03) begin
						hdrSw = `IPA_SW_PARAM; // R23
					end else if (hdrStart ? (haChain | rrqChain | (mipState != M_HA)) :
					             !rrqChain) begin
						hdrSw     = `IPA_SW_SEQ; // R4
						hdrSeqErr = 1'b1;
					end else if (cmdP2[1] & (cmdLc < `IPA_EXT_HDR_BYTES)) begin
						hdrSw = `IPA_SW_LEN; // R20
					end
				end
				8'h03: begin
					hdrKind = `IPA_KIND_AAA;
					if (cmdP2 != 8'h00) begin
						hdrSw = `IPA_SW_PARAM; // R23
					end else if ((mipState != M_RRQ) | haChain | rrqChain) begin
						hdrSw     = `IPA_SW_SEQ; // R4
						hdrSeqErr = 1'b1;
					end else if (cmdLc < 8'h02) begin
						hdrSw = `IPA_SW_LEN;
					end
				end
				8'h04: begin
					hdrKind = `IPA_KIND_PKT; // R18
					if (cmdP2 != 8'h00) begin
						hdrSw = `IPA_SW_PARAM; // R23
					end else if (cmdLc == 8'h00) begin
						hdrSw = `IPA_SW_LEN;
					end
				end
				default: begin
					hdrSw = `IPA_SW_PARAM; // R23
				end
			endcase
		end
		hdrOk = (hdrSw == `IPA_SW_OK);
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			state      <= S_IDLE;
			mipState   <= M_IDLE;
			haChain    <= 1'b0;
			rrqChain   <= 1'b0;
			op         <= 3'h0;
			chain      <= 2'h0;
			lc         <= 8'h00;
			cnt        <= 8'h00;
			slot       <= 8'h00;
			highByte   <= 8'h00;
			tailIdx    <= 5'h00;
			secretEnd  <= 1'b0;
			rrqHash    <= 128'h0;
			respSw1    <= 8'h00;
			respSw2    <= 8'h00;
			respLen    <= 5'h00;
			respDigest <= 128'h0;
			secretKind <= 2'h0;
			secretSlot <= 8'h00;
			secretIdx  <= 6'h00;
			hashStart  <= 1'b0;
			hashValid  <= 1'b0;
			hashByte   <= 8'h00;
			hashFinish <= 1'b0;
		end else begin
			hashStart  <= 1'b0;
			hashFinish <= 1'b0;
			if (hashValid & hashReady) begin
				hashValid <= 1'b0;
			end
			if (pop) begin
				cnt <= cnt + 8'h01;
			end
			case (state)
				S_IDLE: begin
					if (cmdValid) begin
						op         <= cmdP1[2:0]; // R2
						chain      <= cmdP2[1:0]; // R12
						lc         <= cmdLc;
						cnt        <= 8'h00;
						secretIdx  <= 6'h00;
						tailIdx    <= 5'h00;
						secretEnd  <= 1'b0;
						secretKind <= hdrKind;
						secretSlot <= hdrStart ? 8'h00 : slot; // R19
						if (hdrOk) begin
							state     <= S_DATA;
							hashStart <= hdrStart;
							case (cmdP1[2:0])
								`IPA_OP_HA: begin
									haChain  <= (cmdP2[1:0] == `IPA_P2_FIRST) |
									            (cmdP2[1:0] == `IPA_P2_NEXT); // R12
									mipState <= cmdP2[1] ? M_HA : M_IDLE; // R5
								end
								`IPA_OP_RRQ: begin
									rrqChain <= !cmdP2[1];
									mipState <= cmdP2[1] ? M_RRQ : M_IDLE;
								end
								`IPA_OP_AAA: begin
									mipState <= M_IDLE; // R24
								end
								default: begin
									// Local operations break any open chain
									if (haChain | rrqChain) begin
										mipState <= M_IDLE;
									end
									haChain  <= 1'b0;
									rrqChain <= 1'b0;
								end
							endcase
						end else begin
							state   <= S_DRAIN; // R23
							respSw1 <= hdrSw[15:8];
							respSw2 <= hdrSw[7:0];
							respLen <= 5'h00;
							if (hdrSeqErr) begin
								mipState <= M_IDLE; // R24
								haChain  <= 1'b0;
								rrqChain <= 1'b0;
							end
						end
					end
				end
				S_DATA: begin
					if (!bytesLeft) begin
						if ((op == `IPA_OP_HA) & isEnd & !secretEnd) begin
							secretEnd <= 1'b1; // R19
							secretIdx <= 6'h00;
							state     <= S_SECRET;
						end else if (((op == `IPA_OP_HA) | (op == `IPA_OP_RRQ)) & !isEnd) begin
							respSw1 <= swOk[15:8]; // R13
							respSw2 <= swOk[7:0];
							respLen <= 5'h00;
							state   <= S_RESP;
						end else begin
							state <= S_FINISH;
						end
					end else if (pop) begin
						if (slotPos) begin
							slot       <= fifoByte;
							secretSlot <= fifoByte; // R8
						end else begin
							hashValid <= 1'b1; // R15
							hashByte  <= fifoByte;
						end
						if ((op == `IPA_OP_AAA) & (cnt == 8'h01)) begin
							highByte <= fifoByte;
						end
						if (secretAfter) begin
							secretIdx <= 6'h00;
							state     <= S_SECRET;
						end
					end
				end
				S_SECRET: begin
					if (secretIdx == secretLen) begin
						if (secretEnd) begin
							state <= S_FINISH;
						end else if (op == `IPA_OP_AAA) begin
							state <= S_TAIL; // R17
						end else begin
							state <= S_DATA;
						end
					end else if (canEmit) begin
						hashValid <= 1'b1;
						hashByte  <= secretByte;
						secretIdx <= secretIdx + 6'h01;
					end
				end
				S_TAIL: begin
					if (tailIdx < `IPA_DIGEST_BYTES) begin
						if (canEmit) begin
							hashValid <= 1'b1; // R21
							hashByte  <= tailWord[127:120];
							tailIdx   <= tailIdx + 5'h01;
						end
					end else if ((tailIdx == `IPA_DIGEST_BYTES) & replay) begin
						if (canEmit) begin
							hashValid <= 1'b1; // R21
							hashByte  <= highByte;
							tailIdx   <= tailIdx + 5'h01;
						end
					end else begin
						state <= S_DATA;
					end
				end
				S_FINISH: begin
					if (!hashValid) begin
						hashFinish <= 1'b1; // R9
						state      <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (hashDone) begin
						respSw1 <= swOk[15:8];
						respSw2 <= swOk[7:0];
						if (op == `IPA_OP_RRQ) begin
							rrqHash <= hashDigest; // R16
							respLen <= 5'h00;
						end else begin
							respDigest <= hashDigest; // R7
							respLen    <= `IPA_DIGEST_BYTES;
						end
						state <= S_RESP;
					end
				end
				S_DRAIN: begin
					if (!bytesLeft) begin
						state <= S_RESP;
					end
				end
				S_RESP: begin
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule // ipauth_command_engine

`default_nettype wire

// [verification/ipauth_properties.sv]
// Purpose: port checker for the IP authentication command engine
// Assumes: header fields captured on the take edge
// Notes: bound into ipauth_command_engine
`include "ipauth_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ipauth_properties #(
	parameter FIFO_DEPTH  = 8,
	parameter FIFO_ADDR_W = 3
) (
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic       cmdValid,
	input wire logic       cmdReady,
	input wire logic [7:0] cmdClass,
	input wire logic [7:0] cmdIns,
	input wire logic [7:0] cmdP1,
	input wire logic [7:0] cmdP2,
	input wire logic       respValid,
	input wire logic [7:0] respSw1,
	input wire logic [7:0] respSw2,
	input wire logic [4:0] respLen,
	input wire logic       hashStart,
	input wire logic       hashValid,
	input wire logic       hashReady,
	input wire logic [7:0] hashByte,
	input wire logic       hashFinish
);
	logic [7:0] tCla, tIns, tP1, tP2;
	logic       didHash;
	wire        ok = {respSw1, respSw2} == `IPA_SW_OK;
	always @(posedge clk_sys) begin
		if (!resetn) begin
			tCla    <= 8'h00;
			tIns    <= 8'h00;
			tP1     <= 8'h00;
			tP2     <= 8'h00;
			didHash <= 1'b0;
		end else if (cmdValid && cmdReady) begin
			tCla    <= cmdClass;
			tIns    <= cmdIns;
			tP1     <= cmdP1;
			tP2     <= cmdP2;
			didHash <= 1'b0;
		end else if (hashStart || hashValid) begin
			didHash <= 1'b1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	cls_refuse_a: assert property (respValid && tCla != 8'h80 |->
		{respSw1, respSw2} == `IPA_SW_CLA) else $error("foreign class accepted");
	bad_op_a: assert property (respValid && tCla == 8'h80 && tIns == 8'h80
		&& tP1 > 8'h04 |-> {respSw1, respSw2} == `IPA_SW_PARAM) else $error("bad op accepted");
	no_compute_a: assert property (respValid && tP1 > 8'h04 |-> !didHash)
		else $error("hash ran for bad op");
	seq_word_a: assert property (respValid && respSw1 == 8'h98 |->
		respSw2 == 8'h34 && respLen == 5'h00) else $error("order status malformed");
	chap_len_a: assert property (respValid && ok && tP1 == 8'h00 |-> respLen == 5'h10)
		else $error("chap length wrong");
	ha_part_a: assert property (respValid && ok && tP1 == 8'h01 |->
		respLen == (tP2[1] ? 5'h10 : 5'h00)) else $error("ha length wrong");
	rrq_hidden_a: assert property (respValid && tP1 == 8'h02 |-> respLen == 5'h00)
		else $error("rrq digest returned");
	aaa_len_a: assert property (respValid && ok && tP1 == 8'h03 |-> respLen == 5'h10)
		else $error("aaa length wrong");
	finish_gap_a: assert property (hashFinish |-> !hashValid ##1 !hashFinish)
		else $error("finish not clean");
	byte_hold_a: assert property (hashValid && !hashReady |=> hashValid && $stable(hashByte))
		else $error("hash byte dropped");
endmodule // ipauth_properties
bind ipauth_command_engine ipauth_properties #(.FIFO_DEPTH(FIFO_DEPTH),
	.FIFO_ADDR_W(FIFO_ADDR_W)) ipauth_properties_inst (.clk_sys, .resetn, .cmdValid,
	.cmdReady, .cmdClass, .cmdIns, .cmdP1, .cmdP2, .respValid, .respSw1, .respSw2,
	.respLen, .hashStart, .hashValid, .hashReady, .hashByte, .hashFinish);
`default_nettype wire

// [verification/ipauth_far_model.sv]
// Purpose: hash engine and secret store model
// Assumes: digest is a rotate-xor fold, not a real hash
// Notes: slow stalls hashReady every other cycle
`timescale 1ns/1ps
`default_nettype none
module ipauth_far_model (
	input  wire logic         clk_sys,
	input  wire logic         slow,
	input  wire logic [1:0]   secretKind,
	input  wire logic [7:0]   secretSlot,
	input  wire logic [5:0]   secretIdx,
	output logic      [7:0]   secretByte,
	output logic      [5:0]   secretLen,
	input  wire logic         hashStart,
	input  wire logic         hashValid,
	output logic              hashReady,
	input  wire logic [7:0]   hashByte,
	input  wire logic         hashFinish,
	output logic              hashDone,
	output logic      [127:0] hashDigest
);
	logic [7:0]   log[$];
	logic [127:0] lastDigest;
	logic         tick;
	function automatic logic [127:0] fold();
		logic [127:0] a;
		a = 128'h0;
		foreach (log[i]) a = {a[119:0], a[127:120]} ^ {120'h0, log[i]} ^ 128'(i);
		return a;
	endfunction
	// Secret bytes encode kind, slot and index
	assign secretLen  = 6'h04;
	assign secretByte = secretIdx < 6'h04 ? {secretKind, secretSlot[1:0], secretIdx[3:0]}
		: {2'h3, secretIdx};
	assign hashReady  = !slow || tick;
	assign hashDigest = hashDone ? lastDigest : ~lastDigest;
	initial begin
		tick       = 1'b0;
		hashDone   = 1'b0;
		lastDigest = 128'h0;
	end
	always @(posedge clk_sys) begin
		tick     <= ~tick;
		hashDone <= 1'b0;
		if (hashStart) log = {};
		if (hashValid && hashReady) log.push_back(hashByte);
		if (hashFinish) begin
			lastDigest = fold();
			hashDone   <= 1'b1;
		end
	end
endmodule // ipauth_far_model
`default_nettype wire

// [verification/ip_auth_command_engine_tb.sv]
// Purpose: self-checking bench of the IP authentication command engine
// Assumes: far model logs every hashed byte since the last restart
// Notes: inputs change on the falling edge
`include "ipauth_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ip_auth_command_engine_tb;
	logic         clk_sys, resetn, slow, cmdValid, cmdReady, dataValid, dataReady;
	logic [7:0]   cmdClass, cmdIns, cmdP1, cmdP2, cmdLc, dataByte, respSw1, respSw2;
	logic         respValid, hashStart, hashValid, hashReady, hashFinish, hashDone;
	logic [4:0]   respLen;
	logic [127:0] respDigest, hashDigest, rrq;
	logic [1:0]   secretKind;
	logic [7:0]   secretSlot, secretByte, hashByte;
	logic [5:0]   secretIdx, secretLen;
	logic [7:0]   d[$], ex[$];
	int           n_fail = 0, cmp_count = 0;
	ipauth_command_engine ipauth_command_engine_inst (.clk_sys, .resetn, .cmdValid,
		.cmdReady, .cmdClass, .cmdIns, .cmdP1, .cmdP2, .cmdLc, .dataValid, .dataReady,
		.dataByte, .respValid, .respSw1, .respSw2, .respLen, .respDigest, .secretKind,
		.secretSlot, .secretIdx, .secretByte, .secretLen, .hashStart, .hashValid,
		.hashReady, .hashByte, .hashFinish, .hashDone, .hashDigest);
	ipauth_far_model ipauth_far_model_inst (.clk_sys, .slow, .secretKind, .secretSlot,
		.secretIdx, .secretByte, .secretLen, .hashStart, .hashValid, .hashReady,
		.hashByte, .hashFinish, .hashDone, .hashDigest);
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic chkLog();
		chk(128'(ipauth_far_model_inst.log.size()), 128'(ex.size()));
		foreach (ex[i]) chk(ipauth_far_model_inst.log[i], ex[i]);
	endtask
	task automatic sec(input logic [1:0] k, input logic [7:0] s);
		for (int i = 0; i < 4; i++) ex.push_back({k, s[1:0], 4'(i)});
	endtask
	task automatic pushAll();
		foreach (d[i]) begin
			dataByte  = d[i];
			dataValid = 1'b1;
			while (dataReady !== 1'b1) @(negedge clk_sys);
			@(negedge clk_sys);
		end
		dataValid = 1'b0;
	endtask
	task automatic run(input logic [7:0] p1, input logic [7:0] p2, input logic [15:0] sw,
		input logic [4:0] len, input logic [7:0] cla = 8'h80, input bit pre = 0,
		input logic [7:0] ins = 8'h80);
		int n;
		if (pre) begin
			pushAll();
			chk(dataReady, 1'b0);
		end
		cmdClass = cla;
		cmdIns   = ins;
		cmdP1    = p1;
		cmdP2    = p2;
		cmdLc    = 8'(d.size());
		cmdValid = 1'b1;
		while (cmdReady !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		cmdValid = 1'b0;
		if (!pre) pushAll();
		n = 0;
		while (respValid !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 3000) n_fail++;
		chk({respSw1, respSw2}, sw);
		chk(respLen, len);
		@(negedge clk_sys);
	endtask
	task automatic tChap();
		d  = '{8'h11, 8'h02, 8'hA1, 8'hA2, 8'hA3};
		ex = '{8'h11};
		sec(`IPA_KIND_SIMPLE, 8'h02);
		ex = {ex, 8'hA1, 8'hA2, 8'hA3};
		run(8'h00, 8'h00, `IPA_SW_OK, 5'h10);
		chkLog();
		chk(respDigest, ipauth_far_model_inst.lastDigest);
	endtask
	task automatic tPkt();
		d  = '{8'h22, 8'hB1, 8'hB2};
		ex = '{8'h22};
		sec(`IPA_KIND_PKT, 8'h00);
		ex = {ex, 8'hB1, 8'hB2};
		run(8'h04, 8'h00, `IPA_SW_OK, 5'h10);
		chkLog();
		chk(respDigest, ipauth_far_model_inst.lastDigest);
	endtask
	task automatic tOrder();
		d = '{8'h01, 8'h05};
		run(8'h03, 8'h00, `IPA_SW_SEQ, 5'h00);
		d = '{8'h09};
		run(8'h02, 8'h02, `IPA_SW_SEQ, 5'h00);
		run(8'h01, 8'h01, `IPA_SW_SEQ, 5'h00);
	endtask
	task automatic tBad();
		d = '{8'h00};
		run(8'h05, 8'h00, `IPA_SW_PARAM, 5'h00);
		run(8'h01, 8'h04, `IPA_SW_PARAM, 5'h00);
		run(8'h00, 8'h00, `IPA_SW_CLA, 5'h00, 8'h81);
		run(8'h00, 8'h00, `IPA_SW_INS, 5'h00, 8'h80, 0, 8'h81);
		run(8'h00, 8'h00, `IPA_SW_LEN, 5'h00);
	endtask
	task automatic tMip();
		d  = '{8'h01, 8'hC1};
		ex = {};
		sec(`IPA_KIND_HA, 8'h01);
		ex.push_back(8'hC1);
		sec(`IPA_KIND_HA, 8'h01);
		run(8'h01, 8'h02, `IPA_SW_OK, 5'h10);
		chkLog();
		chk(respDigest, ipauth_far_model_inst.lastDigest);
		run(8'h01, 8'h02, `IPA_SW_OK, 5'h10);
		d  = '{8'h03, 8'hD1};
		ex = {};
		sec(`IPA_KIND_HA, 8'h03);
		ex.push_back(8'hD1);
		run(8'h01, 8'h00, `IPA_SW_OK, 5'h00);
		d = '{8'hD2};
		ex.push_back(8'hD2);
		run(8'h01, 8'h01, `IPA_SW_OK, 5'h00);
		d = '{8'hD3};
		ex.push_back(8'hD3);
		sec(`IPA_KIND_HA, 8'h03);
		run(8'h01, 8'h03, `IPA_SW_OK, 5'h10);
		chkLog();
		d = {};
		for (int i = 0; i < 9; i++) d.push_back(8'hE0 + 8'(i));
		ex = d;
		run(8'h02, 8'h02, `IPA_SW_OK, 5'h00);
		chkLog();
		rrq = ipauth_far_model_inst.lastDigest;
		d   = '{8'h02, 8'hF0, 8'hF1, 8'hF2};
		ex  = '{8'hF0};
		sec(`IPA_KIND_AAA, 8'h02);
		for (int i = 15; i >= 0; i--) ex.push_back(rrq[8*i +: 8]);
		ex = {ex, 8'hF0, 8'hF1, 8'hF2};
		run(8'h03, 8'h00, `IPA_SW_OK, 5'h10);
		chkLog();
		chk(respDigest, ipauth_far_model_inst.lastDigest);
		run(8'h03, 8'h00, `IPA_SW_SEQ, 5'h00);
	endtask
	task automatic tFifo();
		slow = 1'b1;
		d    = '{8'h33, 8'h01, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
		ex   = '{8'h33};
		sec(`IPA_KIND_SIMPLE, 8'h01);
		ex = {ex, d[2:7]};
		run(8'h00, 8'h00, `IPA_SW_OK, 5'h10, 8'h80, 1);
		chkLog();
		slow = 1'b0;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		{resetn, slow, cmdValid, dataValid} = 4'h0;
		{cmdClass, cmdIns, cmdP1, cmdP2, cmdLc, dataByte} = 48'h0;
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		tChap();
		tPkt();
		tOrder();
		tBad();
		tMip();
		tFifo();
		report_and_stop();
	end
endmodule // ip_auth_command_engine_tb
`default_nettype wire
